// [rtl/special_trace_pkg.sv]
// Constants shared by the special trace encoder
package special_trace_pkg;
  // Register offsets
  localparam logic [3:0] OFS_CONTROL  = 4'h0;
  localparam logic [3:0] OFS_USER_ONE = 4'h4;
  localparam logic [3:0] OFS_USER_TWO = 4'h8;
  localparam logic [3:0] OFS_TRIG_EN  = 4'hC;
  // Control register field positions
  localparam int BIT_ILLEGAL = 31;
  localparam int BIT_CAUSE   = 15;
  localparam int BIT_DELTA   = 14;
  localparam int BIT_FDT     = 13;
  localparam int BIT_MATCH   = 12;
  localparam int BIT_FAULT   = 11;
  localparam int BIT_CALL    = 10;
  localparam int BIT_SPECIAL = 9;
  localparam int BIT_OFFCHIP = 3;
  localparam int BIT_STALL   = 2;
  localparam int BIT_ENABLE  = 1;
  // Reset values
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [6:0]  TRIG_RESET    = 7'h00;
  // Bus and message sizes
  localparam int DATA_W  = 57;
  localparam int PAY_W   = 47;
  localparam int NUM_BP  = 7;
  localparam int NUM_SLOT = 6;
  // Message codes
  localparam logic [1:0] CODE_ROLL  = 2'h0;
  localparam logic [2:0] CODE_USER  = 3'h2;
  localparam logic [1:0] CODE_MATCH = 2'h1;
  localparam logic [2:0] CODE_FDT   = 3'h3;
  localparam logic [3:0] CODE_CRE   = 4'h7;
  localparam logic [3:0] CODE_OVF   = 4'hF;
  localparam logic [3:0] CODE_JMP8  = 4'h3;
  localparam logic [3:0] CODE_JMP16 = 4'hB;
  localparam logic [3:0] CODE_FULL  = 4'h7;
  localparam logic [3:0] ID_MULTI   = 4'h7;
  // Delta count start of field per message type
  localparam int DPOS_USER  = 36;
  localparam int DPOS_MATCH = 39;
  localparam int DPOS_FDT   = 47;
  localparam logic [9:0] DELTA_MAX = 10'h3FF;
  // Pending slots, emitted lowest index first
  localparam int SLOT_FDT   = 0;
  localparam int SLOT_MATCH = 1;
  localparam int SLOT_CRE   = 2;
  localparam int SLOT_USER1 = 3;
  localparam int SLOT_USER2 = 4;
  localparam int SLOT_OVF   = 5;
  // Normal mode flow kinds
  typedef enum logic [1:0] {
    FLOW_SEQ    = 2'b00,
    FLOW_BRANCH = 2'b01,
    FLOW_JUMP   = 2'b10,
    FLOW_NONE   = 2'b11
  } flow_t;
endpackage

// [rtl/special_trace_encoder.sv]
// Trace message generator for normal and special trace modes
`timescale 1ns/1ps
module special_trace_encoder
  import special_trace_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  input  wire logic                          clkEn,
  // Register port
  input  wire logic [3:0]                    regAddr,
  input  wire logic [31:0]                   regWdata,
  input  wire logic                          regWr,
  input  wire logic                          regRd,
  output logic      [31:0]                   regRdata,
  // Retired instruction
  input  wire logic                          retireValid,
  input  wire logic [31:0]                   retirePc,
  input  wire logic                          retireFullIsa,
  input  wire special_trace_pkg::flow_t      retireFlow,
  // Breakpoint matches
  input  wire logic [special_trace_pkg::NUM_BP-1:0] instMatch,
  input  wire logic [special_trace_pkg::NUM_BP-1:0] dataMatch,
  // Load/store access of a data match
  input  wire logic                          accLoad,
  input  wire logic [3:0]                    accLanes,
  input  wire logic [7:2]                    accAddr,
  input  wire logic [31:0]                   accData,
  // Decoded flow-change classes
  input  wire logic                          callIns,
  input  wire logic                          retIns,
  input  wire logic                          faultRetIns,
  input  wire logic                          handlerFirst,
  // Formatter could not drain in time
  input  wire logic                          drainLate,
  // Trace bus
  output logic                               traceValid,
  output logic      [special_trace_pkg::DATA_W-1:0] traceData
);

  // Control state
  logic [15:0]       ctl;          // Writable control bits
  logic [15:0]       next_ctl;
  logic [NUM_BP-1:0] trigEn;       // Per-breakpoint trigger enable
  logic [NUM_BP-1:0] next_trigEn;
  logic [31:0]       next_regRdata;

  // Decoded modes
  logic illegal;                   // Unsupported combination
  logic normalOn;                  // Normal trace active
  logic specialOn;                 // Some special mode active
  logic modeMatch;
  logic modeFdt;
  logic modeCre;
  logic useDelta;

  // Count of set bits, used for legality and match ids
  function automatic logic [3:0] popCount(input logic [NUM_BP-1:0] v);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < NUM_BP; i++)
      c = c + {3'h0, v[i]};
    return c;
  endfunction

  // Unit number of a match; overlap reports seven
  function automatic logic [3:0] matchId(input logic [NUM_BP-1:0] v);
    logic [3:0] id;
    id = 4'h0;
    for (int i = 0; i < NUM_BP; i++)
      if (v[i])
        id = 4'(i);
    if (popCount(v) > 4'h1)
      id = ID_MULTI;
    return id;
  endfunction

  // Mode decode
  always_comb
  begin
    // Special request in any form; delta counting alone is harmless
    logic [2:0] kinds;
    kinds = {ctl[BIT_MATCH], ctl[BIT_FDT], ctl[BIT_CALL] | ctl[BIT_FAULT]};
    illegal = (ctl[BIT_SPECIAL] && popCount({4'h0, kinds}) > 4'h1)
           || (!ctl[BIT_SPECIAL] && (kinds != 3'h0));
    normalOn  = ctl[BIT_ENABLE] && !ctl[BIT_SPECIAL];
    specialOn = ctl[BIT_ENABLE] && ctl[BIT_SPECIAL] && !illegal;
    modeMatch = specialOn && ctl[BIT_MATCH];
    modeFdt   = specialOn && ctl[BIT_FDT];
    modeCre   = specialOn && (ctl[BIT_CALL] || ctl[BIT_FAULT]);
    useDelta  = specialOn && ctl[BIT_DELTA];
  end

  // Register next values; read data stands one cycle after the strobe
  always_comb
  begin
    next_ctl      = ctl;
    next_trigEn   = trigEn;
    next_regRdata = 32'h0000_0000;
    if (regWr && regAddr == OFS_CONTROL)
      next_ctl = regWdata[15:0];
    if (regWr && regAddr == OFS_TRIG_EN)
      next_trigEn = regWdata[NUM_BP-1:0];
    if (regRd)
    begin
      unique case (regAddr)
        OFS_CONTROL: next_regRdata = {illegal, 15'h0000, ctl};
        OFS_TRIG_EN: next_regRdata = {25'h0000000, trigEn};
        default:     next_regRdata = 32'h0000_0000;  // User words and holes read zero
      endcase
    end
  end

  // Register state
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ctl      <= CONTROL_RESET;
      trigEn   <= TRIG_RESET;
      regRdata <= 32'h0000_0000;
    end
    else if (clkEn)
    begin
      ctl      <= next_ctl;
      trigEn   <= next_trigEn;
      regRdata <= next_regRdata;
    end
  end

  // Pending special messages, one slot per type
  logic [NUM_SLOT-1:0] pend;
  logic [NUM_SLOT-1:0] next_pend;
  logic [NUM_SLOT-1:0] zeroDelta;   // Slot reports delta zero
  logic [NUM_SLOT-1:0] next_zeroDelta;
  logic [PAY_W-1:0]    pay      [NUM_SLOT];
  logic [PAY_W-1:0]    next_pay [NUM_SLOT];
  logic [9:0]          cnt;         // Cycles since last message
  logic [9:0]          next_cnt;
  logic [31:0]         lastPc;      // Reference for normal offsets
  logic [31:0]         next_lastPc;
  logic                lastIsa;
  logic                next_lastIsa;
  logic                needFull;    // First record after start sends full PC
  logic                next_needFull;
  logic                next_traceValid;
  logic [DATA_W-1:0]   next_traceData;

  // Event capture terms
  logic [NUM_SLOT-1:0] due;
  logic [PAY_W-1:0]    newPay [NUM_SLOT];
  logic [NUM_BP-1:0]   instHit;
  logic [NUM_BP-1:0]   dataHit;
  logic [31:0]         fdtWord;
  logic                fcFlag;
  logic                exFlag;
  logic                backFlag;
  logic                userOne;
  logic                userTwo;

  // Build the payload of every message that is due this cycle
  always_comb
  begin
    instHit  = instMatch & trigEn;
    dataHit  = dataMatch & trigEn;
    userOne  = regWr && regAddr == OFS_USER_ONE;
    userTwo  = regWr && regAddr == OFS_USER_TWO;
    fcFlag   = callIns && ctl[BIT_CALL];
    exFlag   = handlerFirst && ctl[BIT_FAULT];
    backFlag = (retIns && ctl[BIT_CALL])
            || (faultRetIns && ctl[BIT_FAULT]);
    // Narrow accesses carry the lane mask ahead of padding
    unique case (popCount({3'h0, accLanes}))
      4'h3:    fdtWord = {accLanes, 4'h0, accData[23:0]};
      4'h2:    fdtWord = {accLanes, 12'h000, accData[15:0]};
      4'h1:    fdtWord = {accLanes, 20'h00000, accData[7:0]};
      default: fdtWord = accData;
    endcase
    due = '0;
    for (int i = 0; i < NUM_SLOT; i++)
      newPay[i] = '0;
    // Filtered data record, one per cycle with any enabled data match
    due[SLOT_FDT] = modeFdt && (dataHit != '0);
    newPay[SLOT_FDT] = {fdtWord, accAddr, (accLanes == 4'hF), accLoad,
                        matchId(dataHit), CODE_FDT};
    // Match record; the cause form follows filtered data
    if (modeMatch && (instHit | dataHit) != '0)
    begin
      due[SLOT_MATCH] = 1'b1;
      newPay[SLOT_MATCH] = {8'h00, retireFullIsa, retirePc[31:1],
                            (instHit != '0), matchId(instHit | dataHit),
                            CODE_MATCH};
    end
    else if (modeFdt && ctl[BIT_CAUSE] && dataHit != '0)
    begin
      due[SLOT_MATCH] = 1'b1;
      newPay[SLOT_MATCH] = {8'h00, retireFullIsa, retirePc[31:1], 1'b0,
                            matchId(dataHit), CODE_MATCH};
    end
    // Call, return and handler entry marker
    due[SLOT_CRE] = modeCre && (fcFlag || exFlag || backFlag);
    newPay[SLOT_CRE] = {8'h00, retireFullIsa, retirePc[31:2], 1'b0,
                        backFlag, exFlag, fcFlag, CODE_CRE};
    // User words from the register port
    due[SLOT_USER1] = specialOn && userOne;
    due[SLOT_USER2] = specialOn && userTwo;
    newPay[SLOT_USER1] = {11'h000, 1'b0, regWdata, CODE_USER};
    newPay[SLOT_USER2] = {11'h000, 1'b1, regWdata, CODE_USER};
    // Overflow only when off-chip and not allowed to stall
    due[SLOT_OVF] = ctl[BIT_ENABLE] && ctl[BIT_OFFCHIP] && !ctl[BIT_STALL]
                 && (drainLate || (due[4:0] & pend[4:0]) != '0);
    newPay[SLOT_OVF] = {43'h0, CODE_OVF};
  end

  // Delta field start for each slot type
  function automatic int deltaPos(input int slot);
    int p;
    p = DPOS_MATCH;
    if (slot == SLOT_FDT)
      p = DPOS_FDT;
    if (slot == SLOT_USER1 || slot == SLOT_USER2)
      p = DPOS_USER;
    return p;
  endfunction

  // Pick the next message and advance the slots and counter
  always_comb
  begin
    logic       sent;
    logic       first;
    logic [9:0] dv;
    logic [31:0] pcDiff;
    sent            = 1'b0;
    first           = 1'b1;
    dv              = 10'h000;
    pcDiff          = retirePc - lastPc;
    next_pend       = pend;
    next_zeroDelta  = zeroDelta;
    next_lastPc     = lastPc;
    next_lastIsa    = lastIsa;
    next_needFull   = needFull || !normalOn;
    next_traceValid = 1'b0;
    next_traceData  = '0;
    for (int i = 0; i < NUM_SLOT; i++)
      next_pay[i] = pay[i];
    if (pend != '0)
    begin
      // Lowest pending slot goes first
      for (int i = NUM_SLOT - 1; i >= 0; i--)
        if (pend[i])
        begin
          dv = zeroDelta[i] ? 10'h000 : cnt;
          next_traceData = {10'h000, pay[i]};
          if (useDelta && i != SLOT_OVF)
            next_traceData = {10'h000, pay[i]}
                           | (DATA_W'(dv) << deltaPos(i));
        end
      for (int i = 0; i < NUM_SLOT; i++)
        if (pend[i] && !sent)
        begin
          next_pend[i] = 1'b0;
          sent = 1'b1;
        end
      next_traceValid = 1'b1;
    end
    else if (useDelta && cnt == DELTA_MAX && due == '0)
    begin
      next_traceValid = 1'b1;
      next_traceData  = {55'h0, CODE_ROLL};
      sent            = 1'b1;
    end
    else if (normalOn && retireValid && retireFlow != FLOW_NONE)
    begin
      // Normal flow record; special slots are idle here
      next_traceValid = 1'b1;
      next_lastPc     = retirePc;
      next_lastIsa    = retireFullIsa;
      next_needFull   = 1'b0;
      if (retireFlow == FLOW_SEQ && !needFull)
        next_traceData = '0;
      else if (retireFlow == FLOW_BRANCH && !needFull)
        next_traceData = {56'h0, 1'b1};
      else if (!needFull && lastIsa == retireFullIsa
               && pcDiff[31:8] == {24{pcDiff[8]}})
        next_traceData = {45'h0, pcDiff[8:1], CODE_JMP8};
      else if (!needFull && lastIsa == retireFullIsa
               && pcDiff[31:16] == {16{pcDiff[16]}})
        next_traceData = {37'h0, pcDiff[16:1], CODE_JMP16};
      else
        next_traceData = {21'h0, retireFullIsa, retirePc[31:1],
                          CODE_FULL};
    end
    else if (normalOn && ctl[BIT_OFFCHIP] && !ctl[BIT_STALL] && drainLate)
    begin
      next_traceValid = 1'b1;
      next_traceData  = {53'h0, CODE_OVF};
      next_needFull   = 1'b1;
    end
    // Capture wins over the clear of the same slot
    for (int i = 0; i < NUM_SLOT; i++)
      if (due[i])
      begin
        next_pend[i]      = 1'b1;
        next_pay[i]       = newPay[i];
        next_zeroDelta[i] = !first || (pend != '0);
        first = 1'b0;
      end
    // Count active cycles since the last message
    if (sent)
      next_cnt = 10'h001;
    else if (cnt == DELTA_MAX)
      next_cnt = cnt;
    else
      next_cnt = cnt + 10'h001;
    if (!specialOn)
      next_pend = '0;
  end

  // Slot, counter and trace bus registers
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pend       <= '0;
      zeroDelta  <= '0;
      cnt        <= 10'h000;
      lastPc     <= 32'h0000_0000;
      lastIsa    <= 1'b0;
      needFull   <= 1'b1;
      traceValid <= 1'b0;
      traceData  <= '0;
      for (int i = 0; i < NUM_SLOT; i++)
        pay[i] <= '0;
    end
    else if (clkEn)
    begin
      pend       <= next_pend;
      zeroDelta  <= next_zeroDelta;
      cnt        <= next_cnt;
      lastPc     <= next_lastPc;
      lastIsa    <= next_lastIsa;
      needFull   <= next_needFull;
      traceValid <= next_traceValid;
      traceData  <= next_traceData;
      for (int i = 0; i < NUM_SLOT; i++)
        pay[i] <= next_pay[i];
    end
  end

endmodule

// [bench/special_trace_asserts.sv]
// Port-level assertion checker for the special trace encoder
`timescale 1ns/1ps
module special_trace_asserts
  import special_trace_pkg::*;
(
  // Clock, reset, enable
  input wire logic              clk_sys,
  input wire logic              rst,
  input wire logic              clkEn,
  // Register port
  input wire logic [3:0]        regAddr,
  input wire logic [31:0]       regWdata,
  input wire logic              regWr,
  // Trace bus
  input wire logic              traceValid,
  input wire logic [DATA_W-1:0] traceData
);
  logic [15:0] ctl;       // Shadow of the writable control bits
  logic [15:0] next_ctl;  // Next shadow value
  logic        specOn;    // Special tracing switched on
  logic        userOne;   // Accepted write to the first user word
  logic        userTwo;   // Accepted write to the second user word

  // Shadow follows control writes, so mode-dependent checks need no peeking
  always_comb
  begin
    next_ctl = ctl;
    if (regWr && clkEn && regAddr == OFS_CONTROL)
    begin
      next_ctl = regWdata[15:0];
    end
  end

  // Shadow register
  always_ff @(posedge clk_sys)
  begin
    ctl <= rst ? CONTROL_RESET : next_ctl;
  end

  assign specOn  = ctl[BIT_ENABLE] && ctl[BIT_SPECIAL];
  assign userOne = regWr && clkEn && regAddr == OFS_USER_ONE && specOn;
  assign userTwo = regWr && clkEn && regAddr == OFS_USER_TWO && specOn;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_roll_upper: assert property (
    traceValid && traceData[1:0] == CODE_ROLL |-> traceData[56:2] == '0)
    else $error("rollover word carries bits above its code");
  a_ovf_upper: assert property (
    traceValid && traceData[3:0] == CODE_OVF |-> traceData[56:4] == '0)
    else $error("overflow word carries bits above its code");
  a_user_upper: assert property (
    traceValid && traceData[2:0] == CODE_USER |-> traceData[56:46] == '0)
    else $error("user word carries bits above its delta field");
  a_match_upper: assert property (
    traceValid && traceData[1:0] == CODE_MATCH |-> traceData[56:49] == '0)
    else $error("match word carries bits above its delta field");
  a_cre_upper: assert property (
    traceValid && traceData[3:0] == CODE_CRE |-> traceData[56:49] == '0)
    else $error("call or return word carries bits above its delta field");
  a_user_one: assert property (
    userOne |-> ##[2:12] (traceValid && traceData[2:0] == CODE_USER && !traceData[35]))
    else $error("first user word write gave no message one");
  a_user_two: assert property (
    userTwo |-> ##[2:12] (traceValid && traceData[2:0] == CODE_USER && traceData[35]))
    else $error("second user word write gave no message two");
  a_ovf_offchip: assert property (
    traceValid && traceData[3:0] == CODE_OVF |-> ctl[BIT_OFFCHIP] && !ctl[BIT_STALL])
    else $error("overflow word outside off-chip tracing without stall");
  a_cause_follow: assert property (
    traceValid && traceData[2:0] == CODE_FDT && specOn && ctl[BIT_FDT] && ctl[BIT_CAUSE]
    |=> traceValid && traceData[1:0] == CODE_MATCH && traceData[48:39] == '0)
    else $error("filtered data word not followed by zero-delta match word");
endmodule

bind special_trace_encoder special_trace_asserts special_trace_asserts_i (
  .clk_sys, .rst, .clkEn, .regAddr, .regWdata, .regWr, .traceValid, .traceData);

// [bench/trace_sink.sv]
// Formatter stand-in: logs every trace word and models a small store
`timescale 1ns/1ps
module trace_sink
  import special_trace_pkg::*;
#(
  parameter int DEPTH = 2  // Words the store holds before it loses one
)
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Bench stops draining while high
  input  wire logic              hold,
  // Trace bus from the encoder
  input  wire logic              traceValid,
  input  wire logic [DATA_W-1:0] traceData,
  // Store could not take a word
  output logic                   drainLate
);
  logic [DATA_W-1:0] log_q[$];  // Every word seen, for the bench
  int                fill;      // Words held in the store

  // Drain before accepting, so one word a cycle never builds up
  always @(posedge clk_sys)
  begin
    drainLate <= 1'h0;
    if (rst)
    begin
      fill = 0;
    end
    else
    begin
      if (!hold && fill > 0)
      begin
        fill = fill - 1;
      end
      // Data only counts in a valid cycle
      if (traceValid)
      begin
        log_q.push_back(traceData);
        // Full store: report it, but never for the overflow word itself
        if (fill == DEPTH)
        begin
          drainLate <= (traceData[3:0] != CODE_OVF);
        end
        else
        begin
          fill = fill + 1;
        end
      end
    end
  end
endmodule

// [bench/testbench.sv]
// Self-checking bench for the special trace encoder
`timescale 1ns/1ps
module testbench
  import special_trace_pkg::*;
;
  // Design ports
  logic              clk_sys = 1'h0;
  logic              rst = 1'h1;
  logic [3:0]        regAddr = 4'h0;
  logic [31:0]       regWdata = 32'h0;
  logic              regWr = 1'h0;
  logic              regRd = 1'h0;
  logic [31:0]       regRdata;
  logic              retireValid = 1'h0;
  logic [31:0]       retirePc = 32'h12345678;
  logic              retireFullIsa = 1'h1;
  flow_t             retireFlow = FLOW_SEQ;
  logic [6:0]        instMatch = 7'h0;
  logic [6:0]        dataMatch = 7'h0;
  logic              accLoad = 1'h1;
  logic [3:0]        accLanes = 4'hF;
  logic [7:2]        accAddr = 6'h2A;
  logic [31:0]       accData = 32'hCAFEF00D;
  logic              callIns = 1'h0, retIns = 1'h0, faultRetIns = 1'h0, handlerFirst = 1'h0;
  logic              drainLate;
  logic              traceValid;
  logic [DATA_W-1:0] traceData;
  // Bench state
  logic              hold = 1'h0;
  int                num_errors = 0;
  int                total_checks = 0;
  int                cycles = 0;
  logic [2:0]        crFlags [4] = '{3'h1, 3'h4, 3'h4, 3'h2};  // Return, entry, call bits
  logic [56:0]       creMask = {8'hFF, 10'h0, 1'h1, 31'h0, 7'h7F};

  special_trace_encoder special_trace_encoder_i (
    .clk_sys, .rst, .clkEn(1'h1), .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .retireValid, .retirePc, .retireFullIsa, .retireFlow, .instMatch, .dataMatch,
    .accLoad, .accLanes, .accAddr, .accData, .callIns, .retIns, .faultRetIns,
    .handlerFirst, .drainLate, .traceValid, .traceData);
  trace_sink trace_sink_i (.clk_sys, .rst, .hold, .traceValid, .traceData, .drainLate);

  always #2.5 clk_sys = ~clk_sys;

  // Compare and count
  task automatic chk(input string n, input logic [56:0] s, input logic [56:0] e);
    total_checks++;
    if (s !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      num_errors++;
    end
  endtask

  // One-cycle register write
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {regAddr, regWdata, regWr} <= {a, d, 1'h1};
    @(posedge clk_sys);
    regWr <= 1'h0;
  endtask

  // One-cycle read, data looked at in the following cycle only
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    {regAddr, regRd} <= {a, 1'h1};
    @(posedge clk_sys);
    regRd <= 1'h0;
    #1 chk("regRdata", 57'(regRdata), 57'(e));
  endtask

  // One retired instruction with its match and flow events
  task automatic ev(input flow_t f, input logic [6:0] im, input logic [6:0] dm,
                    input logic [3:0] fl);
    @(posedge clk_sys);
    retireFlow <= f;
    {retireValid, instMatch, dataMatch, callIns, retIns, faultRetIns, handlerFirst}
      <= {1'h1, im, dm, fl};
    @(posedge clk_sys);
    {retireValid, instMatch, dataMatch, callIns, retIns, faultRetIns, handlerFirst} <= '0;
  endtask

  // Next logged word under a mask; waits a bounded time
  task automatic pop(input logic [56:0] e, input logic [56:0] m, input int lim);
    logic [56:0] s;
    s = 'x;
    for (int i = 0; i < lim && trace_sink_i.log_q.size() == 0; i++)
      @(negedge clk_sys);
    if (trace_sink_i.log_q.size() > 0)
      s = trace_sink_i.log_q.pop_front();
    chk("traceData", s & m, e & m);
  endtask

  // Nothing may appear for n cycles
  task automatic none(input int n);
    repeat (n) @(negedge clk_sys);
    chk("words logged", 57'(trace_sink_i.log_q.size()), 57'h0);
  endtask

  function automatic logic [56:0] matchMsg(input logic [3:0] id, input logic ins);
    return {18'h0, retireFullIsa, retirePc[31:1], ins, id, CODE_MATCH};
  endfunction

  function automatic logic [56:0] userMsg(input logic two, input logic [31:0] d);
    return {21'h0, two, d, CODE_USER};
  endfunction

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Hang guard, well above the roughly 1200 cycles the run needs
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      num_errors++;
      final_report();
    end
  end

  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'h0;
    rd(OFS_CONTROL, 32'h0);
    rd(4'h1, 32'h0);
    wr(OFS_CONTROL, 32'h3202);
    rd(OFS_CONTROL, 32'h80003202);
    $display("test registers done");
    // Normal mode: full PC first, then sequential and predictable branch
    wr(OFS_CONTROL, 32'h2);
    ev(FLOW_JUMP, 7'h0, 7'h0, 4'h0);
    pop({21'h0, 1'h1, retirePc[31:1], CODE_FULL}, '1, 40);
    ev(FLOW_SEQ, 7'h0, 7'h0, 4'h0);
    pop(57'h0, '1, 40);
    ev(FLOW_BRANCH, 7'h0, 7'h0, 4'h0);
    pop(57'h1, '1, 40);
    // Short and medium jumps from the last traced PC
    retirePc <= 32'h123456B8;
    ev(FLOW_JUMP, 7'h0, 7'h0, 4'h0);
    pop({45'h0, 8'h20, CODE_JMP8}, '1, 40);
    retirePc <= 32'h123466B8;
    ev(FLOW_JUMP, 7'h0, 7'h0, 4'h0);
    pop({37'h0, 16'h0800, CODE_JMP16}, '1, 40);
    none(8);
    $display("test normal done");
    // Match mode with trigger enables on units 0 and 2
    wr(OFS_CONTROL, 32'h1202);
    wr(OFS_TRIG_EN, 32'h5);
    rd(OFS_TRIG_EN, 32'h5);
    retireFullIsa <= 1'h0;
    ev(FLOW_JUMP, 7'h04, 7'h0, 4'h0);
    pop(matchMsg(4'h2, 1'h1), '1, 40);
    ev(FLOW_SEQ, 7'h02, 7'h0, 4'h0);
    none(8);
    ev(FLOW_SEQ, 7'h05, 7'h0, 4'h0);
    pop(matchMsg(4'h7, 1'h1), '1, 40);
    none(8);
    // Filtered data, plain then with cause address and delta
    wr(OFS_CONTROL, 32'h2202);
    ev(FLOW_SEQ, 7'h0, 7'h04, 4'h0);
    pop({10'h0, accData, accAddr, 2'h3, 4'h2, CODE_FDT}, '1, 40);
    none(8);
    wr(OFS_CONTROL, 32'hE202);
    {accLoad, accLanes, accData} <= {1'h0, 4'hC, 32'h0000BEEF};
    ev(FLOW_SEQ, 7'h0, 7'h05, 4'h0);
    pop({10'h0, 4'hC, 12'h0, 16'hBEEF, accAddr, 2'h0, 4'h7, CODE_FDT},
        {10'h0, {47{1'h1}}}, 40);
    pop(matchMsg(4'h7, 1'h0), '1, 4);
    $display("test match and data done");
    // Call, return, fault return and handler entry
    wr(OFS_CONTROL, 32'h0E02);
    retireFullIsa <= 1'h1;
    for (int k = 0; k < 4; k++)
    begin
      ev(FLOW_JUMP, 7'h0, 7'h0, 4'(4'h8 >> k));
      pop({18'h0, 1'h1, 31'h0, crFlags[k], CODE_CRE}, creMask, 40);
    end
    wr(OFS_USER_ONE, 32'hA5A50001);
    wr(OFS_USER_TWO, 32'h5A5A0002);
    pop(userMsg(1'h0, 32'hA5A50001), '1, 40);
    pop(userMsg(1'h1, 32'h5A5A0002), '1, 40);
    wr(OFS_CONTROL, 32'h0602);
    ev(FLOW_SEQ, 7'h0, 7'h0, 4'h1);
    none(8);
    $display("test calls and user done");
    // Store held full: overflow only without the stall bit
    for (int k = 0; k < 2; k++)
    begin
      wr(OFS_CONTROL, 32'h060A | (k << 2));
      hold <= 1'h1;
      repeat (3) wr(OFS_USER_ONE, 32'h1);
      repeat (3) pop(userMsg(1'h0, 32'h1), '1, 40);
      if (k == 0)
        pop(57'hF, '1, 40);
      hold <= 1'h0;
      none(8);
    end
    // Quiet line with delta counting ends in a rollover word
    wr(OFS_CONTROL, 32'h4602);
    wr(OFS_USER_ONE, 32'h2);
    pop(userMsg(1'h0, 32'h2), {21'h0, {36{1'h1}}}, 40);
    none(1000);
    pop(57'h0, '1, 40);
    $display("test overflow and rollover done");
    final_report();
  end
endmodule
